/* File: hw/tws_map.svh */
// Purpose: Command codes, field positions and reset values of the two-wire slave
// Assumes: Included by the slave and the bench; definitions only
// Notes: Base address value is arbitrary and neutral
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// Command codes; temperature has a second code for its low byte
`define TWS_CMD_DIV       8'h5D
`define TWS_CMD_CTRL      8'h60
`define TWS_CMD_TEMP      8'h64
`define TWS_CMD_TEMP_LO   8'h65
`define TWS_CMD_TRIM      8'h66

// Output control field positions
`define TWS_CTRL_HALF     0
`define TWS_CTRL_TEST     1
`define TWS_CTRL_BASE_EN  2
`define TWS_CTRL_DIV_EN   3
`define TWS_CTRL_MASK     8'h0F

// Tuning register layout
`define TWS_TRIM_SIGN     7

// Reset and fill values
`define TWS_REG_RESET     8'h00
`define TWS_RATIO_RESET   10'h001
`define TWS_RATIO_ONE     10'h001
`define TWS_TEMP_PAD      6'h00
`define TWS_RD_NONE       8'h00

// Byte framing counts
`define TWS_BITS_BYTE     4'h8
`define TWS_BIT_ZERO      4'h0
`define TWS_BIT_ONE       4'h1

// Upper six address bits, value arbitrary
`define TWS_BASE_ADDR     6'h2A

`endif

/* File: hw/tws_pkg.sv */
// Purpose: Types shared by the two-wire command slave
// Assumes: No constants taken from tws_map.svh; state codes are literal
// Notes: One state struct per clock domain
package tws_pkg;

	// Serial engine states
	typedef enum logic [2:0] {
		TWS_IDLE     = 3'b000,
		TWS_ADDR     = 3'b001,
		TWS_ADDR_ACK = 3'b010,
		TWS_WR_BYTE  = 3'b011,
		TWS_WR_ACK   = 3'b100,
		TWS_RD_BYTE  = 3'b101,
		TWS_RD_ACK   = 3'b110,
		TWS_RD_MORE  = 3'b111
	} tws_state_t;

	// Link domain state
	typedef struct packed {
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_d;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_d;
		logic        strap_s1;
		logic        strap_s2;
		logic        tt_s1;
		logic        tt_s2;
		logic        tt_d;
		tws_state_t  st;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic        rw;
		logic [7:0]  cmd;
		logic [1:0]  phase;
		logic        idx;
		logic [15:0] temp_live;
		logic [15:0] temp_snap;
		logic [7:0]  div;
		logic [7:0]  ctrl;
		logic [7:0]  trim;
		logic        wr_tgl;
		logic        sda_oen;
		logic        sda_o;
	} tws_link_t;

	// Core domain state
	typedef struct packed {
		logic        wt_s1;
		logic        wt_s2;
		logic        wt_d;
		logic [15:0] temp_hold;
		logic        temp_tgl;
		logic [7:0]  div;
		logic [7:0]  ctrl;
		logic [7:0]  trim_pend;
		logic [9:0]  ratio;
		logic        trim_sign;
		logic [6:0]  trim_mag;
	} tws_core_t;

endpackage

/* File: hw/tws_cmd_slave.sv */
// Purpose: Two-wire slave with command-selected registers and thermometer readout
// Assumes: SCL and SDA oversampled on LINK_CLK_I; temperature word arrives on core clock
// Notes: Link and core domains meet only through toggle handshakes
// Operation
// R1 - Temperature command returns the latest completed conversion, one or two bytes
// R2 - Master wanting whole degrees may read one byte, NACK, then STOP
// R3 - Temperature is two's complement; low byte holds halves, quarters, zero padding
// R4 - Divider, control and tuning commands each access exactly one byte
// R5 - Tuning value offsets oscillator loading, shifting base frequency
// R6 - Pointer never advances; command must be resent before every access
// R7 - Device is slave only; master makes clock, START and STOP
// R8 - Works at both 100 kHz and 400 kHz serial clock
// R9 - SDA falling while SCL high is a START
// R10 - SDA rising while SCL high is a STOP ending the transfer
// R11 - Data changes only while SCL low; one clock pulse per bit
// R12 - Bytes travel MSB first, each followed by a ninth acknowledge bit
// R13 - Acknowledger holds SDA low through the high phase of the ACK pulse
// R14 - On master NACK the device releases SDA so a STOP can follow
// R15 - First byte is 7-bit address plus direction; one bit from strap
// R16 - On address match the device acknowledges in either direction
// R17 - In writes the device acknowledges every byte after its address
// R18 - Master acknowledges every read byte except the last
// R19 - STOP or repeated START ends a transfer; master sets byte count
// R20 - Master starts only when both lines are idle high
// R21 - In transmit mode read data is shifted out timed by SCL
// R22 - Divided output ratio is n+1, or twice that with half-duty set
// R23 - Tuning is sign plus 7-bit magnitude, applied at next temperature update
// R24 - Software writes zero to the factory test bit
// R25 - Output control resets to zero; bits half, test, base, divided enables
// R26 - First write byte is the command; reads use command write then repeated START
// R27 - Both temperature bytes come from one snapshot taken when the read begins
// R28 - Unknown commands change nothing; writes to temperature are ignored
`timescale 1ns/100ps
`include "tws_map.svh"

module tws_cmd_slave
#(
	parameter logic [5:0] BASE_ADDR = `TWS_BASE_ADDR
)
(
	input  wire logic       CORE_CLK_I,
	input  wire logic       LINK_CLK_I,
	input  wire logic       RSTN_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OEN_O,
	input  wire logic       ADDR_STRAP_I,
	input  wire logic [9:0] TEMP_WORD_I,
	input  wire logic       TEMP_VALID_I,
	output logic [7:0]      DIV_VALUE_O,
	output logic [9:0]      DIVIDE_RATIO_O,
	output logic            HALF_DUTY_O,
	output logic            FACTORY_TEST_O,
	output logic            BASE_OUT_EN_O,
	output logic            DIVIDED_OUT_EN_O,
	output logic            TRIM_SIGN_O,
	output logic [6:0]      TRIM_MAG_O
);
	import tws_pkg::*;

	// Idle reset images; line syncs start high so no false edge at release
	localparam tws_link_t LINK_INIT = '{
		scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
		sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
		st: TWS_IDLE, sda_oen: 1'b1, default: '0};
	localparam tws_core_t CORE_INIT = '{ratio: `TWS_RATIO_RESET, default: '0};

	logic [1:0] core_rst_pipe;
	logic [1:0] link_rst_pipe;
	logic       core_rstn;
	logic       link_rstn;
	tws_link_t  l_q;
	tws_link_t  l_n;
	tws_core_t  c_q;
	tws_core_t  c_n;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic       addr_hit;
	logic       byte_done;

	// Read data mux; pointer is the command alone, never advanced
	function automatic logic [7:0] rd_byte(
		input logic [7:0]  cmd,
		input logic        idx,
		input logic [15:0] snap,
		input logic [7:0]  dv,
		input logic [7:0]  ct,
		input logic [7:0]  tr
	);
		logic [7:0] val;
		val = `TWS_RD_NONE;
		case (cmd)
			`TWS_CMD_DIV:     val = dv; // R4
			`TWS_CMD_CTRL:    val = ct; // R4
			`TWS_CMD_TEMP:    val = idx ? snap[7:0] : snap[15:8]; // R1
			`TWS_CMD_TEMP_LO: val = snap[7:0];
			`TWS_CMD_TRIM:    val = tr; // R4
			default:          val = `TWS_RD_NONE;
		endcase
		return val;
	endfunction

	// Division ratio seen by the divider
	function automatic logic [9:0] div_ratio(
		input logic [7:0] n,
		input logic       half
	);
		logic [9:0] base;
		base = {2'b00, n} + `TWS_RATIO_ONE;
		return half ? {base[8:0], 1'b0} : base; // R22
	endfunction

	// Reset release per domain; assertion is asynchronous
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			core_rst_pipe <= 2'b00;
		else
			core_rst_pipe <= {core_rst_pipe[0], 1'b1};
	end

	always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			link_rst_pipe <= 2'b00;
		else
			link_rst_pipe <= {link_rst_pipe[0], 1'b1};
	end

	assign core_rstn = core_rst_pipe[1];
	assign link_rstn = link_rst_pipe[1];

	// Line events from synchronised copies; 12 ns sampling covers fast mode
	assign scl_rise   = l_q.scl_s2 & ~l_q.scl_d; // R8
	assign scl_fall   = ~l_q.scl_s2 & l_q.scl_d;
	assign start_seen = l_q.scl_s2 & l_q.scl_d & l_q.sda_d & ~l_q.sda_s2; // R9
	assign stop_seen  = l_q.scl_s2 & l_q.scl_d & ~l_q.sda_d & l_q.sda_s2; // R10
	assign addr_hit   = (l_q.shreg[7:1] == {BASE_ADDR, l_q.strap_s2}); // R15
	assign byte_done  = scl_fall & (l_q.bitcnt == `TWS_BITS_BYTE);

	// Serial engine; SCL is only ever sampled, never driven
	always_comb
	begin
		l_n = l_q;
		l_n.scl_s1   = SCL_I; // R7
		l_n.scl_s2   = l_q.scl_s1;
		l_n.scl_d    = l_q.scl_s2;
		l_n.sda_s1   = SDA_I;
		l_n.sda_s2   = l_q.sda_s1;
		l_n.sda_d    = l_q.sda_s2;
		l_n.strap_s1 = ADDR_STRAP_I;
		l_n.strap_s2 = l_q.strap_s1;
		l_n.tt_s1    = c_q.temp_tgl;
		l_n.tt_s2    = l_q.tt_s1;
		l_n.tt_d     = l_q.tt_s2;
		l_n.sda_o    = 1'b0;
		// Core holds the word stable long after its toggle
		if (l_q.tt_s2 != l_q.tt_d)
			l_n.temp_live = c_q.temp_hold; // R1
		if (start_seen)
		begin
			// Repeated START keeps the command for a following read
			l_n.st      = TWS_ADDR; // R19 R26
			l_n.bitcnt  = `TWS_BIT_ZERO;
			l_n.phase   = 2'd0;
			l_n.sda_oen = 1'b1;
		end
		else if (stop_seen)
		begin
			l_n.st      = TWS_IDLE; // R10
			l_n.sda_oen = 1'b1;
		end
		else
		begin
			unique case (l_q.st)
				TWS_IDLE:
				begin
					l_n.sda_oen = 1'b1;
				end
				TWS_ADDR:
				begin
					if (scl_rise)
					begin
						l_n.shreg  = {l_q.shreg[6:0], l_q.sda_s2}; // R12
						l_n.bitcnt = l_q.bitcnt + `TWS_BIT_ONE;
					end
					else if (byte_done)
					begin
						if (addr_hit)
						begin
							l_n.rw      = l_q.shreg[0];
							l_n.sda_oen = 1'b0; // R16
							l_n.st      = TWS_ADDR_ACK;
							if (l_q.shreg[0])
								l_n.temp_snap = l_q.temp_live; // R27
						end
						else
							l_n.st = TWS_IDLE;
					end
				end
				TWS_ADDR_ACK:
				begin
					// Hold the ACK low until SCL falls again
					if (scl_fall) // R13
					begin
						l_n.bitcnt = `TWS_BIT_ZERO;
						if (l_q.rw)
						begin
							l_n.idx     = 1'b0;
							l_n.shreg   = rd_byte(l_q.cmd, 1'b0, l_q.temp_snap, l_q.div, l_q.ctrl, l_q.trim);
							l_n.sda_oen = l_n.shreg[7]; // R21
							l_n.st      = TWS_RD_BYTE;
						end
						else
						begin
							l_n.sda_oen = 1'b1;
							l_n.st      = TWS_WR_BYTE;
						end
					end
				end
				TWS_WR_BYTE:
				begin
					if (scl_rise)
					begin
						l_n.shreg  = {l_q.shreg[6:0], l_q.sda_s2}; // R12
						l_n.bitcnt = l_q.bitcnt + `TWS_BIT_ONE;
					end
					else if (byte_done)
					begin
						l_n.sda_oen = 1'b0; // R17
						l_n.st      = TWS_WR_ACK;
						unique case (l_q.phase)
							2'd0:
							begin
								l_n.cmd   = l_q.shreg; // R26
								l_n.phase = 2'd1;
							end
							2'd1:
							begin
								// One data byte per command; further bytes are dropped
								l_n.phase = 2'd2; // R6
								case (l_q.cmd)
									`TWS_CMD_DIV:
									begin
										l_n.div    = l_q.shreg; // R4
										l_n.wr_tgl = ~l_q.wr_tgl;
									end
									`TWS_CMD_CTRL:
									begin
										l_n.ctrl   = l_q.shreg & `TWS_CTRL_MASK; // R25
										l_n.wr_tgl = ~l_q.wr_tgl;
									end
									`TWS_CMD_TRIM:
									begin
										l_n.trim   = l_q.shreg; // R5
										l_n.wr_tgl = ~l_q.wr_tgl;
									end
									default:
									begin
										l_n.phase = 2'd2; // R28
									end
								endcase
							end
							2'd2, 2'd3:
							begin
								l_n.phase = 2'd2;
							end
						endcase
					end
				end
				TWS_WR_ACK:
				begin
					if (scl_fall)
					begin
						l_n.sda_oen = 1'b1;
						l_n.bitcnt  = `TWS_BIT_ZERO;
						l_n.st      = TWS_WR_BYTE;
					end
				end
				TWS_RD_BYTE:
				begin
					if (scl_rise)
						l_n.bitcnt = l_q.bitcnt + `TWS_BIT_ONE;
					else if (byte_done)
					begin
						l_n.sda_oen = 1'b1;
						l_n.st      = TWS_RD_ACK;
					end
					else if (scl_fall)
					begin
						// Next bit goes out only in the low phase
						l_n.shreg   = {l_q.shreg[6:0], 1'b0}; // R11
						l_n.sda_oen = l_q.shreg[6]; // R21
					end
				end
				TWS_RD_ACK:
				begin
					if (scl_rise)
					begin
						if (l_q.sda_s2)
							l_n.st = TWS_IDLE; // R14
						else
							l_n.st = TWS_RD_MORE;
					end
				end
				TWS_RD_MORE:
				begin
					// Second temperature byte; other registers repeat their byte
					if (scl_fall)
					begin
						l_n.idx     = 1'b1;
						l_n.bitcnt  = `TWS_BIT_ZERO;
						l_n.shreg   = rd_byte(l_q.cmd, 1'b1, l_q.temp_snap, l_q.div, l_q.ctrl, l_q.trim);
						l_n.sda_oen = l_n.shreg[7];
						l_n.st      = TWS_RD_BYTE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge LINK_CLK_I or negedge link_rstn)
	begin
		if (!link_rstn)
			l_q <= LINK_INIT;
		else
			l_q <= l_n;
	end

	// Core side: register copies, temperature capture, tuning apply
	always_comb
	begin
		c_n = c_q;
		c_n.wt_s1 = l_q.wr_tgl;
		c_n.wt_s2 = c_q.wt_s1;
		c_n.wt_d  = c_q.wt_s2;
		// Link data is quiet for many cycles after its toggle
		if (c_q.wt_s2 != c_q.wt_d)
		begin
			c_n.div       = l_q.div;
			c_n.ctrl      = l_q.ctrl; // R24
			c_n.trim_pend = l_q.trim;
			c_n.ratio     = div_ratio(l_q.div, l_q.ctrl[`TWS_CTRL_HALF]); // R22
		end
		if (TEMP_VALID_I)
		begin
			c_n.temp_hold = {TEMP_WORD_I, `TWS_TEMP_PAD}; // R3
			c_n.temp_tgl  = ~c_q.temp_tgl;
			c_n.trim_sign = c_q.trim_pend[`TWS_TRIM_SIGN]; // R23
			c_n.trim_mag  = c_q.trim_pend[6:0]; // R23
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge core_rstn)
	begin
		if (!core_rstn)
			c_q <= CORE_INIT;
		else
			c_q <= c_n;
	end

	// Outputs straight from state flops
	assign SDA_O            = l_q.sda_o;
	assign SDA_OEN_O        = l_q.sda_oen;
	assign DIV_VALUE_O      = c_q.div;
	assign DIVIDE_RATIO_O   = c_q.ratio;
	assign HALF_DUTY_O      = c_q.ctrl[`TWS_CTRL_HALF];
	assign FACTORY_TEST_O   = c_q.ctrl[`TWS_CTRL_TEST];
	assign BASE_OUT_EN_O    = c_q.ctrl[`TWS_CTRL_BASE_EN];
	assign DIVIDED_OUT_EN_O = c_q.ctrl[`TWS_CTRL_DIV_EN];
	assign TRIM_SIGN_O      = c_q.trim_sign;
	assign TRIM_MAG_O       = c_q.trim_mag;

	// Link domain checks; the last one runs on the core clock
	chk_start_to_addr: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R9
		start_seen |=> (l_q.st == TWS_ADDR) && (l_q.bitcnt == `TWS_BIT_ZERO) && l_q.sda_oen)
		else $error("START not followed by address phase");

	chk_stop_release: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R10
		stop_seen |=> (l_q.st == TWS_IDLE) && l_q.sda_oen)
		else $error("STOP did not idle the engine");

	chk_addr_ack_match: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R16
		(l_q.st == TWS_ADDR) && byte_done && addr_hit && !start_seen && !stop_seen
		|=> !l_q.sda_oen && (l_q.st == TWS_ADDR_ACK))
		else $error("matching address not acknowledged");

	chk_addr_ignore_miss: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R15
		(l_q.st == TWS_ADDR) && byte_done && !addr_hit && !start_seen && !stop_seen
		|=> l_q.sda_oen && (l_q.st == TWS_IDLE))
		else $error("foreign address answered");

	chk_write_ack_all: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R17
		(l_q.st == TWS_WR_BYTE) && byte_done && !start_seen && !stop_seen |=> !l_q.sda_oen)
		else $error("written byte not acknowledged");

	chk_ack_held_low: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R13
		((l_q.st == TWS_WR_ACK) || (l_q.st == TWS_ADDR_ACK)) && l_q.scl_s2 && !stop_seen && !start_seen
		|-> !l_q.sda_oen ##1 !l_q.sda_oen)
		else $error("ACK released during SCL high");

	chk_sda_change_low: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R11
		!$stable(l_q.sda_oen) |-> $past(scl_fall || start_seen || stop_seen))
		else $error("SDA changed outside SCL low phase");

	chk_nack_release: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R14
		(l_q.st == TWS_RD_ACK) && scl_rise && l_q.sda_s2 && !start_seen && !stop_seen
		|=> l_q.sda_oen && (l_q.st == TWS_IDLE) ##1 l_q.sda_oen)
		else $error("SDA not released after master NACK");

	chk_snap_steady: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R27
		(l_q.st == TWS_RD_BYTE) || (l_q.st == TWS_RD_ACK) || (l_q.st == TWS_RD_MORE)
		|=> $stable(l_q.temp_snap))
		else $error("temperature snapshot torn during read");

	chk_ptr_fixed: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R6
		(l_q.st == TWS_RD_BYTE) || (l_q.st == TWS_RD_ACK) || (l_q.st == TWS_RD_MORE) |=> $stable(l_q.cmd))
		else $error("register pointer moved during read");

	chk_unknown_cmd: assert property (@(posedge LINK_CLK_I) disable iff (!link_rstn) // R28
		(l_q.st == TWS_WR_BYTE) && byte_done && (l_q.phase == 2'd1) && (l_q.cmd != `TWS_CMD_DIV)
		&& (l_q.cmd != `TWS_CMD_CTRL) && (l_q.cmd != `TWS_CMD_TRIM)
		|=> $stable(l_q.div) && $stable(l_q.ctrl) && $stable(l_q.trim) && $stable(l_q.wr_tgl))
		else $error("register changed by unknown command");

	chk_ratio_formula: assert property (@(posedge CORE_CLK_I) disable iff (!core_rstn) // R22
		$changed(c_q.ctrl) && !c_q.ctrl[`TWS_CTRL_HALF] |-> c_q.ratio == ({2'b00, c_q.div} + `TWS_RATIO_ONE))
		else $error("divide ratio does not match n+1");

	// Main scenarios
	cov_temp_two_bytes: cover property (@(posedge LINK_CLK_I) disable iff (!link_rstn)
		(l_q.st == TWS_RD_MORE) && scl_fall && (l_q.cmd == `TWS_CMD_TEMP));
	cov_reg_write: cover property (@(posedge LINK_CLK_I) disable iff (!link_rstn)
		$changed(l_q.wr_tgl));
	cov_one_byte_nack: cover property (@(posedge LINK_CLK_I) disable iff (!link_rstn)
		(l_q.st == TWS_RD_ACK) && scl_rise && l_q.sda_s2 && !l_q.idx);
	cov_repeat_start: cover property (@(posedge LINK_CLK_I) disable iff (!link_rstn)
		start_seen && (l_q.st != TWS_IDLE));

endmodule

/* File: sim/tws_bus_master.sv */
// Purpose: Two-wire bus master model facing the slave
// Assumes: Open-drain SDA with pull-up in the bench; SCL driven directly
// Notes: SCL stands high between frames; q is a quarter bit in core cycles
`timescale 1ns/100ps

module tws_bus_master
(
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o = 1'b1,
	output logic      sda_low_o = 1'b0
);
	int q = 10;

	// Quarter of a bit period
	task automatic tick();
		repeat (q) @(posedge clk_i);
	endtask

	// START or repeated START, only ever made here
	task automatic start();
		sda_low_o <= 1'b0;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_low_o <= 1'b1;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask

	// STOP leaves the bus idle
	task automatic stop();
		sda_low_o <= 1'b1;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_low_o <= 1'b0;
		tick();
	endtask

	// Change SDA while low, sample mid-high so slow answers still land
	task automatic bit_x(input logic b, output logic r);
		sda_low_o <= ~b;
		tick();
		scl_o <= 1'b1;
		tick();
		r = sda_i;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask

	// Byte out MSB first; ninth bit is the slave's answer
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	// Byte in; the last byte of a read is left unacknowledged
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the two-wire command slave
// Assumes: Master model paced by the core clock; SDA pulled up here
// Notes: Most traffic runs above 400 kHz to keep the run short
`timescale 1ns/100ps
`include "tws_map.svh"

module tb;
	logic       core_clk  = 1'b0;
	logic       link_clk  = 1'b0;
	logic       rstn      = 1'b0;
	logic       strap     = 1'b0;
	logic [9:0] temp_word = 10'h000;
	logic       temp_vld  = 1'b0;
	logic       a;
	wire logic  scl, sda_low, dut_sda, dut_oen, tsign, sda;
	wire logic [7:0] div_v;
	wire logic [9:0] ratio;
	wire logic [3:0] ctrl_o;
	wire logic [6:0] tmag;
	logic [7:0] e_div = 8'h00, e_ctrl = 8'h00, e_trim = 8'h00, e_tapp = 8'h00;
	logic [9:0] e_temp = 10'h000;
	logic [7:0] cmds [3] = '{`TWS_CMD_DIV, `TWS_CMD_CTRL, `TWS_CMD_TRIM};
	logic [9:0] temps [7] = '{10'h154, 10'h12C, 10'h002, 10'h000, 10'h3FE, 10'h3B0, 10'h360};
	int         seed      = 319;
	int         errors    = 0;
	int         cmp_count = 0;

	// Unrelated clocks; open-drain wire with pull-up
	always #5 core_clk = ~core_clk;
	always #6 link_clk = ~link_clk;
	assign sda = ~(sda_low | (~dut_oen & ~dut_sda));

	tws_cmd_slave dut_u (.CORE_CLK_I(core_clk), .LINK_CLK_I(link_clk), .RSTN_I(rstn), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(dut_sda), .SDA_OEN_O(dut_oen), .ADDR_STRAP_I(strap), .TEMP_WORD_I(temp_word),
		.TEMP_VALID_I(temp_vld), .DIV_VALUE_O(div_v), .DIVIDE_RATIO_O(ratio), .HALF_DUTY_O(ctrl_o[0]),
		.FACTORY_TEST_O(ctrl_o[1]), .BASE_OUT_EN_O(ctrl_o[2]), .DIVIDED_OUT_EN_O(ctrl_o[3]),
		.TRIM_SIGN_O(tsign), .TRIM_MAG_O(tmag));
	tws_bus_master mst_u (.clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

	function automatic logic [9:0] ratio_f(input logic [7:0] n, input logic h);
		logic [9:0] r;
		r = {2'b00, n} + 10'h001;
		return h ? {r[8:0], 1'b0} : r;
	endfunction

	// Later read bytes of divider, control and tuning repeat, temperature gives its low byte; the pointer never moves
	function automatic logic [7:0] rd_exp(input logic [7:0] c, input logic i, input logic [9:0] w);
		case (c)
			`TWS_CMD_DIV:     return e_div;
			`TWS_CMD_CTRL:    return e_ctrl;
			`TWS_CMD_TRIM:    return e_trim;
			`TWS_CMD_TEMP:    return i ? {w[1:0], 6'h00} : w[9:2];
			`TWS_CMD_TEMP_LO: return {w[1:0], 6'h00};
			default:          return 8'h00;
		endcase
	endfunction

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_ack(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic chk_outs();
		chk("divider value", {8'h00, e_div}, {8'h00, div_v});
		chk("divide ratio", {6'h00, ratio_f(e_div, e_ctrl[0])}, {6'h00, ratio});
		chk("control bits", {12'h000, e_ctrl[3:0]}, {12'h000, ctrl_o});
		chk("trim", {8'h00, e_tapp}, {8'h00, tsign, tmag});
	endtask

	task automatic addr(input logic rw);
		mst_u.wr_byte({`TWS_BASE_ADDR, strap, rw}, a);
		chk_ack("addr ack", 1'b1, a);
	endtask

	// Command then n data bytes; each data byte is the inverse of the one before
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n);
		mst_u.start();
		addr(1'b0);
		mst_u.wr_byte(c, a);
		chk_ack("cmd ack", 1'b1, a);
		case (c)
			`TWS_CMD_DIV:  e_div = d;
			`TWS_CMD_CTRL: e_ctrl = d & `TWS_CTRL_MASK;
			`TWS_CMD_TRIM: e_trim = d;
			default:       ;
		endcase
		repeat (n)
		begin
			mst_u.wr_byte(d, a);
			chk_ack("data ack", 1'b1, a);
			d = ~d;
		end
		mst_u.stop();
	endtask

	// Command write, repeated START, n bytes; temperature expected as at the restart
	task automatic rd(input logic [7:0] c, input int n);
		logic [7:0] v;
		logic [9:0] s;
		mst_u.start();
		addr(1'b0);
		mst_u.wr_byte(c, a);
		chk_ack("cmd ack", 1'b1, a);
		mst_u.start();
		s = e_temp;
		addr(1'b1);
		for (int i = 0; i < n; i++)
		begin
			mst_u.rd_byte(i == n - 1, v);
			chk("read byte", {8'h00, rd_exp(c, i != 0, s)}, {8'h00, v});
		end
		repeat (6) @(posedge core_clk);
		chk_ack("sda released", 1'b1, sda);
		mst_u.stop();
	endtask

	task automatic temp_in(input logic [9:0] w);
		temp_word <= w;
		temp_vld <= 1'b1;
		@(posedge core_clk);
		temp_vld <= 1'b0;
		e_temp = w;
		e_tapp = e_trim;
		repeat (12) @(posedge core_clk);
	endtask

	// Hang guard
	initial
	begin
		repeat (99000) @(posedge core_clk);
		errors++;
		$display("CHECK FAILED run length expected end seen timeout");
		close_out();
	end

	// Main sequence
	initial
	begin
		logic [7:0] c;
		logic [7:0] d;
		@(posedge core_clk);
		strap <= 1'($random(seed));
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk_outs();
		foreach (cmds[i])
			rd(cmds[i], 1);
		mst_u.start();
		mst_u.wr_byte({`TWS_BASE_ADDR, ~strap, 1'b0}, a);
		chk_ack("foreign addr ack", 1'b0, a);
		mst_u.stop();
		$display("test reset and address done");
		for (int k = 0; k < 6; k++)
		begin
			c = (k < 3) ? cmds[k] : cmds[$unsigned($random(seed)) % 3];
			d = 8'($random(seed));
			if (c == `TWS_CMD_CTRL)
				d = d & 8'h0D;
			wr(c, d, 1);
			rd(c, 2);
			chk_outs();
			temp_in(10'($random(seed)));
			chk_outs();
		end
		$display("test registers done");
		wr(`TWS_CMD_DIV, 8'hFF, 1);
		wr(`TWS_CMD_CTRL, 8'h01, 1);
		chk_outs();
		wr(8'h61, 8'hA5, 1);
		wr(`TWS_CMD_TEMP, 8'hA5, 1);
		wr(`TWS_CMD_DIV, 8'h3C, 3);
		chk_outs();
		rd(`TWS_CMD_DIV, 1);
		rd(8'h61, 1);
		$display("test corners done");
		foreach (temps[i])
		begin
			temp_in(temps[i]);
			rd(`TWS_CMD_TEMP, 1 + i % 2);
		end
		rd(`TWS_CMD_TEMP_LO, 1);
		fork
			rd(`TWS_CMD_TEMP, 2);
			begin
				repeat (1350) @(posedge core_clk);
				temp_in(10'h0AA);
			end
		join
		rd(`TWS_CMD_TEMP, 2);
		$display("test temperature done");
		mst_u.q = 250;
		wr(`TWS_CMD_TRIM, 8'h9C, 1);
		mst_u.q = 63;
		rd(`TWS_CMD_TRIM, 1);
		mst_u.q = 10;
		$display("test rates done");
		rstn <= 1'b0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		{e_div, e_ctrl, e_trim, e_tapp, e_temp} = '0;
		repeat (10) @(posedge core_clk);
		chk_outs();
		rd(`TWS_CMD_TEMP, 2);
		$display("test second reset done");
		close_out();
	end
endmodule
